// ===== hw/fsr1_map.svh
`ifndef FSR1_MAP_SVH
`define FSR1_MAP_SVH

// ==========================================
// Bit positions
`define FSR1_BIT_PROTECT_LO   7
`define FSR1_BIT_GRANULE      6
`define FSR1_BIT_DIRECTION    5
`define FSR1_EXTENT_HI        4
`define FSR1_EXTENT_LO        2
`define FSR1_BIT_WEL          1
`define FSR1_BIT_BUSY         0
`define FSR1_WRITABLE_MASK    8'h_00FC
`define FSR1_RESET_VALUE      8'h_0000

// ==========================================
// Opcodes and indirect address
`define FSR1_OP_WRITE_SR1     8'h_0001
`define FSR1_OP_READ_SR1      8'h_0005
`define FSR1_OP_WRITE_EN      8'h_0006
`define FSR1_OP_WRITE_DIS     8'h_0004
`define FSR1_OP_VOL_WRITE_EN  8'h_0050
`define FSR1_OP_IND_READ      8'h_0065
`define FSR1_OP_IND_WRITE     8'h_0071
`define FSR1_IND_ADDR_SR1     8'h_0001
`define FSR1_OP_PAGE_PROG     8'h_0002
`define FSR1_OP_ERASE_4K      8'h_0020
`define FSR1_OP_ERASE_32K     8'h_0052
`define FSR1_OP_ERASE_64K     8'h_00D8
`define FSR1_OP_CHIP_ERASE_A  8'h_0060
`define FSR1_OP_CHIP_ERASE_B  8'h_00C7

// ==========================================
// Protection geometry (22-bit byte address)
`define FSR1_ADDR_W           22
`define FSR1_SHIFT_64K        5'h_0010
`define FSR1_SHIFT_4K         5'h_000C
`define FSR1_EXTENT_ALL       3'h_7

`endif

// ===== hw/fsr1_pkg.sv
package fsr1_pkg;

  // ==========================================
  // Command event from the serial command decoder
  typedef struct packed {
    logic        valid;
    logic        aborted;
    logic        complete;
    logic [7:0]  opcode;
    logic [7:0]  regAddr;
    logic [7:0]  data;
    logic [21:0] target;
  } fsr1_cmd_t;

  // ==========================================
  // Outcome toward the array engine
  typedef struct packed {
    logic grant;
    logic refuse;
    logic nvWrite;
  } fsr1_result_t;

endpackage

// ===== hw/fsr1_status_reg.sv
`include "fsr1_map.svh"

// How it works
// - Bit 7 is a read/write register-protect bit, zero at reset.
// - Bit 6 picks protect granule: zero 64 KB, one 4 KB.
// - Bit 5 picks direction: zero from bottom, one from top.
// - Bits 4:2 hold block-protect extent; zero protects nothing.
// - Opcode 01h loads the protect fields; host uses it.
// - Program and erase aimed at a protected region are refused.
// - With latch clear, program and erase are ignored; status writes too, unless 50h came before them.
// - Write-enable latch clears on power-up and reset.
// - Incomplete or unknown command cut short keeps the latch set.
// - Early abort clears latch only after a complete write-type command.
// - Opcode 06h sets the latch; 50h leaves it alone.
// - Bit 0 busy flag follows the internal program/erase, zero at reset.
// - Opcode 05h reads the register.
// - Indirect 65h read and 71h write with address 01h reach it.
// - Write enabled by 50h alone loads nvData but pulses no nvWrite; with the latch set by 06h it also pulses nvWrite.
module fsr1_status_reg
  import fsr1_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire fsr1_cmd_t    cmd,
  input  wire logic         arrayBusy,
  input  wire logic         regLocked,
  output logic [7:0]        statusOut,
  output fsr1_result_t      result,
  output logic [7:0]        nvData
);

  logic [7:2]   protReg;
  logic [7:2]   protNext;
  logic         welReg;
  logic         welNext;
  logic         volEnReg;
  logic         volEnNext;
  logic [7:0]   statusOut_reg;
  fsr1_result_t result_reg;
  fsr1_result_t result_next;
  logic [7:0]   nvData_reg;

  // ==========================================
  // Command decode
  wire logic [7:0] op        = cmd.opcode;
  wire logic       executed  = cmd.valid && !cmd.aborted;
  wire logic       cutShort  = cmd.valid && cmd.aborted;
  wire logic       isStatWr  = (op == `FSR1_OP_WRITE_SR1) ||
                               (op == `FSR1_OP_IND_WRITE && cmd.regAddr == `FSR1_IND_ADDR_SR1);
  wire logic       isChip    = (op == `FSR1_OP_CHIP_ERASE_A) || (op == `FSR1_OP_CHIP_ERASE_B);
  wire logic       isProgEr  = (op == `FSR1_OP_PAGE_PROG) || (op == `FSR1_OP_ERASE_4K) ||
                               (op == `FSR1_OP_ERASE_32K) || (op == `FSR1_OP_ERASE_64K) ||
                               isChip;
  wire logic       isWriteTy = isStatWr || isProgEr;

  // ==========================================
  // Protected-region decode
  wire logic [2:0]  extent    = protReg[`FSR1_EXTENT_HI:`FSR1_EXTENT_LO];
  wire logic [4:0]  granShift = protReg[`FSR1_BIT_GRANULE] ? `FSR1_SHIFT_4K : `FSR1_SHIFT_64K;
  wire logic [4:0]  regShift  = granShift + 5'(extent) - 5'h_0001;
  // Top-down regions are measured from the last byte
  wire logic [21:0] offset    = protReg[`FSR1_BIT_DIRECTION] ? ~cmd.target : cmd.target;
  wire logic [21:0] beyond    = offset >> regShift;
  wire logic       inRegion  = (extent == `FSR1_EXTENT_ALL) ||
                               ((extent != 3'h_0) && (beyond == 22'h_0000));
  wire logic       blocked   = isChip ? (extent != 3'h_0) : inRegion;

  wire logic       statWrOk  = executed && isStatWr && (welReg || volEnReg) &&
                               !regLocked && !arrayBusy;
  wire logic       progTry   = executed && isProgEr && welReg && !arrayBusy;

  // ==========================================
  // Next-state logic
  always_comb
  begin
    protNext    = protReg;
    welNext     = welReg;
    volEnNext   = volEnReg;
    result_next = '0;
    // Volatile enable lasts until the next non-read command
    if (cmd.valid && op != `FSR1_OP_READ_SR1 && op != `FSR1_OP_IND_READ)
      volEnNext = 1'b0;
    if (executed && op == `FSR1_OP_WRITE_EN)
      welNext = 1'b1;
    if (executed && op == `FSR1_OP_WRITE_DIS)
      welNext = 1'b0;
    if (executed && op == `FSR1_OP_VOL_WRITE_EN)
      volEnNext = 1'b1;
    if (statWrOk)
    begin
      protNext = cmd.data[7:2];
      welNext  = 1'b0;
      result_next.nvWrite = welReg;
    end
    if (progTry)
    begin
      welNext = 1'b0;
      result_next.grant  = !blocked;
      result_next.refuse = blocked;
    end
    if (cutShort && cmd.complete && isWriteTy)
      welNext = 1'b0;
  end

  // ==========================================
  // Registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      protReg       <= 6'h_00;
      welReg        <= 1'b0;
      volEnReg      <= 1'b0;
      statusOut_reg <= `FSR1_RESET_VALUE;
      result_reg    <= '0;
      nvData_reg    <= `FSR1_RESET_VALUE;
    end
    else
    begin
      protReg       <= protNext;
      welReg        <= welNext;
      volEnReg      <= volEnNext;
      statusOut_reg <= {protReg, welReg, arrayBusy};
      result_reg    <= result_next;
      nvData_reg    <= statWrOk ? {cmd.data[7:2], 2'b00} : nvData_reg;
    end
  end

  assign statusOut = statusOut_reg;
  assign result    = result_reg;
  assign nvData    = nvData_reg;

  // ==========================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_wel_set;
    executed && op == `FSR1_OP_WRITE_EN |=> welReg ##1 statusOut[`FSR1_BIT_WEL];
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set by 06h");

  property p_vol_keeps;
    executed && op == `FSR1_OP_VOL_WRITE_EN |=> welReg == $past(welReg);
  endproperty
  a_vol_keeps: assert property (p_vol_keeps) else $error("50h changed latch");

  property p_no_wel_ignore;
    executed && isStatWr && !welReg && !volEnReg |=> protReg == $past(protReg);
  endproperty
  a_no_wel_ignore: assert property (p_no_wel_ignore) else $error("write without enable");

  property p_no_wel_prog;
    executed && isProgEr && !welReg |=> !result.grant && !result.refuse;
  endproperty
  a_no_wel_prog: assert property (p_no_wel_prog) else $error("program without enable");

  property p_abort_keep;
    cutShort && !cmd.complete && welReg |=> welReg;
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("latch lost on cut");

  property p_abort_clear;
    cutShort && cmd.complete && isWriteTy |=> !welReg;
  endproperty
  a_abort_clear: assert property (p_abort_clear) else $error("latch kept on abort");

  property p_protected;
    progTry && blocked |=> result.refuse && !result.grant;
  endproperty
  a_protected: assert property (p_protected) else $error("protected target granted");

  property p_busy;
    arrayBusy |=> statusOut[`FSR1_BIT_BUSY] ##1 $past(arrayBusy) == statusOut[`FSR1_BIT_BUSY];
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag wrong");

  property p_write_value;
    statWrOk |=> protReg == $past(cmd.data[7:2]) && !welReg ##1 statusOut[7:2] == $past(protReg);
  endproperty
  a_write_value: assert property (p_write_value) else $error("write value lost");

  property p_nv_path;
    statWrOk |=> result.nvWrite == $past(welReg);
  endproperty
  a_nv_path: assert property (p_nv_path) else $error("nv path wrong");

  property p_vol_only;
    statWrOk && !welReg |=> !result.nvWrite;
  endproperty
  a_vol_only: assert property (p_vol_only) else $error("nv on volatile");

  property p_locked_ignore;
    executed && isStatWr && (regLocked || arrayBusy) |=> protReg == $past(protReg);
  endproperty
  a_locked_ignore: assert property (p_locked_ignore) else $error("locked write");

  property p_unprot_grant;
    progTry && !blocked |=> result.grant && !result.refuse;
  endproperty
  a_unprot_grant: assert property (p_unprot_grant) else $error("open refused");

  property p_status_image;
    statusOut[7:2] == $past(protReg) && statusOut[`FSR1_BIT_WEL] == $past(welReg);
  endproperty
  a_status_image: assert property (p_status_image) else $error("image stale");

  c_grant:   cover property (result.grant);
  c_refuse:  cover property (result.refuse);
  c_vol_wr:  cover property (statWrOk && !welReg);
  c_abort:   cover property (cutShort && welReg);
  c_chip:    cover property (progTry && isChip);

endmodule

// ===== bench/fsr1_host_model.sv
module fsr1_host_model
  import fsr1_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] statusIn,
  output fsr1_cmd_t       cmd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial cmd = '0;

  // ==========
  // Command events
  // one event
  task automatic send(input logic ab, input logic cp, input logic [7:0] op,
                      input logic [7:0] ra, input logic [7:0] d, input logic [21:0] t);
    @(negedge sys_clk);
    cmd <= {1'b1, ab, cp, op, ra, d, t};
    @(negedge sys_clk);
    // Released fields show their inverse
    cmd <= {1'b0, ~cmd[47:0]};
  endtask

  task automatic poll();
    int n;
    n = 0;
    do
    begin
      send(1'b0, 1'b0, 8'h05, 8'h00, 8'h00, 22'h0);
      repeat (2) @(negedge sys_clk);
      n++;
    end
    while (statusIn[0] !== 1'b0 && n < 100);
  endtask
endmodule

// ===== bench/tb_flash_status_register_one.sv
module tb_flash_status_register_one
  import fsr1_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end

  logic         sys_clk = 1'b0;
  logic         reset = 1'b1;
  logic         arrayBusy = 1'b0;
  logic         regLocked = 1'b0;
  fsr1_cmd_t    cmd;
  logic [7:0]   statusOut;
  fsr1_result_t result;
  logic [7:0]   nvData;
  logic [7:0]   nGrant = 8'h00;
  logic [7:0]   nRefuse = 8'h00;
  logic [7:0]   nNv = 8'h00;
  logic [15:0]  base;
  int           fail_count = 0;
  int           tests_run = 0;

  always #20 sys_clk = ~sys_clk;

  fsr1_status_reg u_dut (.sys_clk(sys_clk), .reset(reset), .cmd(cmd), .arrayBusy(arrayBusy),
    .regLocked(regLocked), .statusOut(statusOut), .result(result), .nvData(nvData));
  fsr1_host_model host (.sys_clk(sys_clk), .statusIn(statusOut), .cmd(cmd));

  // ==========
  // Pulse counters
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      nGrant <= 8'h00;
      nRefuse <= 8'h00;
      nNv <= 8'h00;
    end
    else
    begin
      nGrant <= nGrant + {7'h00, result.grant};
      nRefuse <= nRefuse + {7'h00, result.refuse};
      nNv <= nNv + {7'h00, result.nvWrite};
    end
  end

  task automatic run(input logic [7:0] op, input logic [7:0] d = 8'h00,
                     input logic [21:0] t = 22'h0, input logic ab = 1'b0, input logic cp = 1'b0);
    host.send(ab, cp, op, 8'h01, d, t);
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========
  // Tests
  initial
  begin
    repeat (8) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    `CHK("reset image", 8'h00, statusOut)
    run(8'h01, 8'hFC);
    `CHK("write no latch", 8'h00, statusOut)
    run(8'h06);
    `CHK("latch set", 8'h02, statusOut)
    run(8'h01, 8'hFF);
    `CHK("direct write", 8'hFC, statusOut)
    `CHK("nv data", 8'hFC, nvData)
    run(8'h50);
    `CHK("vol enable", 8'hFC, statusOut)
    run(8'h71, 8'h5B);
    `CHK("indirect write", 8'h58, statusOut)
    `CHK("nv pulses", 8'h01, nNv)
    run(8'h05);
    run(8'h65);
    `CHK("reads", 8'h58, statusOut)
    run(8'h06);
    run(8'h01, 8'h00, 22'h0, 1'b1, 1'b0);
    `CHK("short abort", 8'h5A, statusOut)
    run(8'h02, 8'h00, 22'h0, 1'b1, 1'b1);
    `CHK("full abort", 8'h58, statusOut)
    base = {nGrant, nRefuse};
    run(8'h02);
    `CHK("no latch prog", base, {nGrant, nRefuse})
    run(8'h06);
    run(8'h20, 8'h00, 22'h01_F000);
    `CHK("refuse", base + 16'h0001, {nGrant, nRefuse})
    run(8'h06);
    run(8'hD8, 8'h00, 22'h3F_0000);
    `CHK("grant", base + 16'h0101, {nGrant, nRefuse})
    run(8'h06);
    run(8'h04);
    run(8'hC7);
    `CHK("disabled erase", base + 16'h0101, {nGrant, nRefuse})
    run(8'h06);
    run(8'h60);
    `CHK("chip refuse", base + 16'h0102, {nGrant, nRefuse})
    regLocked = 1'b1;
    run(8'h06);
    run(8'h01, 8'h80);
    `CHK("locked", 6'h16, statusOut[7:2])
    regLocked = 1'b0;
    run(8'h06);
    run(8'h01, 8'h80);
    `CHK("protect bit", 8'h80, statusOut)
    arrayBusy = 1'b1;
    run(8'h05);
    `CHK("busy", 8'h81, statusOut)
    fork
      begin
        repeat (20) @(negedge sys_clk);
        arrayBusy = 1'b0;
      end
      host.poll();
    join
    `CHK("ready", 8'h80, statusOut)
    run(8'h06);
    `CHK("latch before reset", 8'h82, statusOut)
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK("latch reset", 8'h00, statusOut)
    end_of_test();
  end

  initial
  begin
    #100us;
    fail_count++;
    end_of_test();
  end
endmodule
